//--- verilog/sra_pkg.sv
// Purpose: Shared constants and carriers of the status record assembler
// Assumes: 32-bit APB, byte stream out
// Notes:   Record offsets are byte positions of the full record
package sra_pkg;
   // ------------------------------------------------------------
   // Record geometry
   // ------------------------------------------------------------
   localparam int          NAX        = 8;
   localparam logic [10:0] HDR_BYTES  = 11'h004;
   localparam logic [10:0] GEN_BYTES  = 11'h04E;
   localparam logic [10:0] AXIS_BYTES = 11'h024;
   localparam logic [10:0] FULL_LEN   = 11'h172;
   localparam int          REC_THREAD = 51;
   localparam int          REC_S_STAT = 64;
   localparam int          REC_T_STAT = 74;
   localparam int          REC_AX0    = 82;
   localparam int          GEN_W      = 624;
   localparam int          AX_W       = 288;
   localparam int          AX_VEL_LSB = 160;
   localparam int          AX_TQ_LSB  = 192;
   localparam int          AX_SW_OFS  = 2;
   localparam int          AX_RES_OFS = 31;
   localparam int          VEL_SHIFT  = 6;
   localparam logic [31:0] TQ_MAX     = 32'h00007FFF;
   localparam logic [31:0] TQ_MIN     = 32'hFFFF8001;
   localparam logic [3:0]  AX_NONE    = 4'h8;
   localparam logic [8:0]  FULL_SEL   = 9'h1FF;

   // ------------------------------------------------------------
   // Register map
   // ------------------------------------------------------------
   localparam logic [11:0] ADDR_SEL   = 12'h000;
   localparam logic [11:0] ADDR_CMD   = 12'h004;
   localparam logic [11:0] ADDR_STAT  = 12'h008;
   localparam logic [11:0] ADDR_ISTAT = 12'h00C;
   localparam logic [11:0] ADDR_IMASK = 12'h010;
   localparam int          INT_DONE   = 0;
   localparam int          INT_BUSY   = 1;
   localparam int          STAT_LEN_LSB = 16;

   typedef struct packed {
      logic move;
      logic slewing;
      logic stopping;
      logic final_decel;
   } sra_plane_t;

   typedef struct packed {
      logic        move;
      logic        pos_mode;
      logic        abs_only;
      logic        edge_search;
      logic        homing_sequence;
      logic        home_ph1;
      logic        home_ph2_index;
      logic        coord_mode;
      logic        neg_dir;
      logic        contour;
      logic        slewing;
      logic        stopping;
      logic        final_decel;
      logic        latch_armed;
      logic        home_ph3;
      logic        motor_off;
      logic        latch_occ;
      logic        latch_in;
      logic        fwd_limit;
      logic        rev_limit;
      logic        home_in;
      logic        stepper;
      logic [7:0]  stop_code;
      logic [31:0] ref_pos;
      logic [31:0] mot_pos;
      logic [31:0] pos_err;
      logic [31:0] aux_pos;
      logic [31:0] velocity;
      logic [31:0] torque;
      logic [15:0] analog;
      logic [7:0]  hall;
      logic [31:0] user_variable_slot;
   } sra_axis_t;

   typedef struct packed {
      logic [7:0] data;
      logic       last;
   } sra_byte_t;
endpackage

//--- verilog/sra_status_record_assembler.sv
// Purpose: Builds the binary status record and streams it byte by byte
// Assumes: Status inputs come from logic on pclk; host stalls via rec_ready
// Notes:   Inputs are captured at start so a record is self-consistent
//
// Local design decisions: the APB interface to the registers and the register offsets.
`timescale 1ns/1ns
`default_nettype none
module sra_status_record_assembler
   import sra_pkg::*;
(
   input  wire logic             pclk,
   input  wire logic             presetn,
   input  wire logic             psel,
   input  wire logic             penable,
   input  wire logic             pwrite,
   input  wire logic [11:0]      paddr,
   input  wire logic [31:0]      pwdata,
   output logic      [31:0]      prdata,
   output logic                  pready,
   output logic                  pslverr,
   output logic                  irq,
   input  wire logic [7:0]       thread_run,
   input  wire sra_plane_t       plane_s,
   input  wire sra_plane_t       plane_t,
   input  wire sra_axis_t [NAX-1:0] axis_in,
   output logic                  rec_valid,
   output sra_byte_t             rec_byte,
   input  wire logic             rec_ready
);
   // ------------------------------------------------------------
   // Field packing
   // ------------------------------------------------------------
   function automatic logic [15:0] plane_word(input sra_plane_t p);
      return {p.move, 9'h000, p.slewing, p.stopping, p.final_decel, 3'h0};
   endfunction

   function automatic logic [AX_W-1:0] axis_vec(input sra_axis_t a);
      logic [15:0] st;
      logic [7:0]  sw;
      logic [31:0] tq;
      st = {a.move, a.pos_mode, a.abs_only, a.edge_search, a.homing_sequence,
            a.home_ph1, a.home_ph2_index, a.coord_mode, a.neg_dir, a.contour,
            a.slewing, a.stopping, a.final_decel, a.latch_armed, a.home_ph3,
            a.motor_off};
      sw = {a.latch_occ, a.latch_in, 2'h0, a.fwd_limit, a.rev_limit,
            a.home_in, a.stepper};
      tq = a.torque;
      if ($signed(a.torque) > $signed(TQ_MAX)) tq = TQ_MAX;
      if ($signed(a.torque) < $signed(TQ_MIN)) tq = TQ_MIN;
      // Lowest byte first gives little-endian fields
      return {a.user_variable_slot, 8'h00, a.hall, a.analog, tq,
              a.velocity <<< VEL_SHIFT, a.aux_pos, a.pos_err, a.mot_pos,
              a.ref_pos, a.stop_code, sw, st};
   endfunction

   function automatic logic [3:0] next_ax(input logic [7:0] m,
                                          input logic [3:0] from);
      logic [3:0] r;
      r = AX_NONE;
      for (int i = NAX - 1; i >= 0; i--) begin
         if (4'(i) >= from && m[i]) r = 4'(i);
      end
      return r;
   endfunction

   // ------------------------------------------------------------
   // Register file
   // ------------------------------------------------------------
   typedef enum logic [1:0] {ST_IDLE, ST_HDR, ST_GEN, ST_AXIS} sra_state_t;

   sra_state_t          state;
   logic [8:0]          sel;
   logic [1:0]          istat;
   logic [1:0]          imask;
   logic [8:0]          msk_q;
   logic [10:0]         len_q;
   logic [7:0]          snap_thr;
   sra_plane_t          snap_s;
   sra_plane_t          snap_t;
   sra_axis_t [NAX-1:0] snap_ax;
   logic [3:0]          ax;
   logic [6:0]          off;
   logic [10:0]         pos;
   logic [10:0]         opos;
   logic                wr_en;
   logic                rd_en;
   logic                start_req;
   logic                start_ok;
   logic                advance;
   logic                done_ev;
   logic [1:0]          set_ev;
   logic [8:0]          eff_sel;
   logic [10:0]         next_len;
   logic [7:0]          cur_byte;
   logic [GEN_W-1:0]    gen_vec;
   logic [AX_W-1:0]     cur_ax_vec;
   logic [15:0]         hdr_word;
   logic                mapped;

   assign wr_en     = psel && penable && pready && pwrite;
   assign rd_en     = psel && !penable;
   assign start_req = wr_en && paddr == ADDR_CMD && pwdata[0];
   assign start_ok  = start_req && state == ST_IDLE;
   assign mapped    = paddr == ADDR_SEL || paddr == ADDR_CMD ||
                      paddr == ADDR_STAT || paddr == ADDR_ISTAT ||
                      paddr == ADDR_IMASK;

   // Zero-wait slave: pready rises in the first access cycle
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready  <= 1'b0;
         pslverr <= 1'b0;
         prdata  <= 32'h0000_0000;
      end else begin
         pready  <= rd_en;
         pslverr <= rd_en && !mapped;
         prdata  <= 32'h0000_0000;
         if (rd_en) begin
            case (paddr)
               ADDR_SEL:   prdata <= {23'h000000, sel};
               ADDR_STAT:  prdata <= {5'h00, len_q, 15'h0000, state != ST_IDLE};
               ADDR_ISTAT: prdata <= {30'h00000000, istat};
               ADDR_IMASK: prdata <= {30'h00000000, imask};
               default:    prdata <= 32'h0000_0000;
            endcase
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sel   <= 9'h000;
         imask <= 2'h0;
      end else if (wr_en) begin
         if (paddr == ADDR_SEL) sel <= pwdata[8:0];
         if (paddr == ADDR_IMASK) imask <= pwdata[1:0];
      end
   end

   // ------------------------------------------------------------
   // Interrupts
   // ------------------------------------------------------------
   assign set_ev = {start_req && state != ST_IDLE, done_ev};

   // Set beats a same-cycle write-one clear
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         istat <= 2'h0;
         irq   <= 1'b0;
      end else begin
         if (wr_en && paddr == ADDR_ISTAT) istat <= (istat & ~pwdata[1:0]) | set_ev;
         else istat <= istat | set_ev;
         irq <= |(istat & imask);
      end
   end

   // ------------------------------------------------------------
   // Record sequencing
   // ------------------------------------------------------------
   // Empty selection returns the whole record
   assign eff_sel = (sel == 9'h000) ? FULL_SEL : sel;

   always_comb begin
      next_len = HDR_BYTES;
      if (eff_sel[NAX]) next_len = next_len + GEN_BYTES;
      for (int i = 0; i < NAX; i++) begin
         if (eff_sel[i]) next_len = next_len + AXIS_BYTES;
      end
   end

   assign hdr_word = {1'b1, 4'h0, {3{msk_q[NAX]}}, msk_q[NAX-1:0]};

   always_comb begin
      gen_vec = '0;
      gen_vec[(REC_THREAD-HDR_BYTES)*8 +: 8] = snap_thr;
      gen_vec[(REC_S_STAT-HDR_BYTES)*8 +: 16] = plane_word(snap_s);
      gen_vec[(REC_T_STAT-HDR_BYTES)*8 +: 16] = plane_word(snap_t);
   end

   assign cur_ax_vec = axis_vec(snap_ax[ax[2:0]]);

   always_comb begin
      case (state)
         ST_HDR: begin
            case (off[1:0])
               2'h0:    cur_byte = hdr_word[7:0];
               2'h1:    cur_byte = hdr_word[15:8];
               2'h2:    cur_byte = len_q[7:0];
               default: cur_byte = {5'h00, len_q[10:8]};
            endcase
         end
         ST_GEN:  cur_byte = gen_vec[off*8 +: 8];
         ST_AXIS: cur_byte = cur_ax_vec[off*8 +: 8];
         default: cur_byte = 8'h00;
      endcase
   end

   assign advance = state != ST_IDLE && (!rec_valid || rec_ready);
   assign done_ev = advance && pos == len_q - 11'h001;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         msk_q    <= 9'h000;
         len_q    <= 11'h000;
         snap_thr <= 8'h00;
         snap_s   <= '0;
         snap_t   <= '0;
         snap_ax  <= '0;
      end else if (start_ok) begin
         msk_q    <= eff_sel;
         len_q    <= next_len;
         snap_thr <= thread_run;
         snap_s   <= plane_s;
         snap_t   <= plane_t;
         snap_ax  <= axis_in;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state <= ST_IDLE;
         ax    <= 4'h0;
         off   <= 7'h00;
         pos   <= 11'h000;
      end else if (start_ok) begin
         state <= ST_HDR;
         off   <= 7'h00;
         pos   <= 11'h000;
      end else if (advance) begin
         pos <= pos + 11'h001;
         off <= off + 7'h01;
         case (state)
            ST_HDR: if (off == 7'(HDR_BYTES - 11'h001)) begin
               off <= 7'h00;
               ax  <= next_ax(msk_q[NAX-1:0], 4'h0);
               if (msk_q[NAX]) state <= ST_GEN;
               else if (next_ax(msk_q[NAX-1:0], 4'h0) == AX_NONE) state <= ST_IDLE;
               else state <= ST_AXIS;
            end
            ST_GEN: if (off == 7'(GEN_BYTES - 11'h001)) begin
               off <= 7'h00;
               if (ax == AX_NONE) state <= ST_IDLE;
               else state <= ST_AXIS;
            end
            ST_AXIS: if (off == 7'(AXIS_BYTES - 11'h001)) begin
               off <= 7'h00;
               ax  <= next_ax(msk_q[NAX-1:0], ax + 4'h1);
               if (next_ax(msk_q[NAX-1:0], ax + 4'h1) == AX_NONE) state <= ST_IDLE;
            end
            default: state <= ST_IDLE;
         endcase
      end
   end

   // ------------------------------------------------------------
   // Byte stream out
   // ------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rec_valid <= 1'b0;
         rec_byte  <= '0;
         opos      <= 11'h000;
      end else if (advance) begin
         rec_valid     <= 1'b1;
         rec_byte.data <= cur_byte;
         rec_byte.last <= done_ev;
         opos          <= pos;
      end else if (rec_ready) begin
         rec_valid <= 1'b0;
      end
   end

   // ------------------------------------------------------------
   // Checks
   // ------------------------------------------------------------
   logic full;
   assign full = msk_q == FULL_SEL;

   a_hdr_fixed_bit: assert property (@(posedge pclk) disable iff (!presetn)
      rec_valid && opos == 11'h001 |-> rec_byte.data[7] && rec_byte.data[6:3] == 4'h0)
      else $error("header bit 15 or unused bits wrong");
   a_hdr_len_bytes: assert property (@(posedge pclk) disable iff (!presetn)
      rec_valid && rec_ready && opos == 11'h002 ##1 rec_valid && opos == 11'h003
      |-> {rec_byte.data[2:0], $past(rec_byte.data)} == len_q)
      else $error("header length bytes wrong");
   a_last_at_len: assert property (@(posedge pclk) disable iff (!presetn)
      rec_valid && rec_byte.last |-> opos == len_q - 11'h001)
      else $error("last byte not at record length");
   a_full_rec_len: assert property (@(posedge pclk) disable iff (!presetn)
      state != ST_IDLE && full |-> len_q == FULL_LEN)
      else $error("full record length wrong");
   a_thread_byte: assert property (@(posedge pclk) disable iff (!presetn)
      rec_valid && full && opos == 11'(REC_THREAD) |-> rec_byte.data == snap_thr)
      else $error("thread byte wrong");
   a_plane_hi_byte: assert property (@(posedge pclk) disable iff (!presetn)
      rec_valid && full && opos == 11'(REC_S_STAT + 1)
      |-> rec_byte.data == {snap_s.move, 7'h00})
      else $error("plane status high byte wrong");
   a_axis_switch: assert property (@(posedge pclk) disable iff (!presetn)
      rec_valid && full && opos == 11'(REC_AX0 + (NAX - 1) * AXIS_BYTES + AX_SW_OFS)
      |-> rec_byte.data[5:4] == 2'h0 && rec_byte.data[3] == snap_ax[7].fwd_limit)
      else $error("axis switch byte wrong");
   a_reserved_zero: assert property (@(posedge pclk) disable iff (!presetn)
      rec_valid && full && opos == 11'(REC_AX0 + (NAX - 1) * AXIS_BYTES + AX_RES_OFS)
      |-> rec_byte.data == 8'h00)
      else $error("reserved byte not zero");
   a_torque_range: assert property (@(posedge pclk) disable iff (!presetn)
      state == ST_AXIS |-> $signed(cur_ax_vec[AX_TQ_LSB +: 32]) <= $signed(TQ_MAX)
      && $signed(cur_ax_vec[AX_TQ_LSB +: 32]) >= $signed(TQ_MIN))
      else $error("torque outside range");
   a_vel_scaled: assert property (@(posedge pclk) disable iff (!presetn)
      state == ST_AXIS |-> cur_ax_vec[AX_VEL_LSB +: 32]
      == snap_ax[ax[2:0]].velocity <<< VEL_SHIFT)
      else $error("velocity not scaled");
   a_axis_move: assert property (@(posedge pclk) disable iff (!presetn)
      rec_valid && full && opos == 11'(REC_AX0 + (NAX - 1) * AXIS_BYTES + 1)
      |-> rec_byte.data[7] == snap_ax[7].move && rec_byte.data[0] == snap_ax[7].coord_mode)
      else $error("axis status high byte wrong");
endmodule
`default_nettype wire

//--- tb/sra_rec_sink.sv
// Purpose: Host side sink of the status record byte stream
// Assumes: One byte accepted per edge with valid and ready high
// Notes:   Slow mode stalls one cycle in four to stretch the stream
`timescale 1ns/1ns
`default_nettype none
module sra_rec_sink
   import sra_pkg::*;
(
   input  wire logic      pclk,
   input  wire logic      presetn,
   input  wire logic      clr,
   input  wire logic      slow,
   input  wire logic      rec_valid,
   input  wire sra_byte_t rec_byte,
   output var logic       rec_ready,
   output var int         n,
   output var int         last_at,
   output var logic       got_last
);
   logic [7:0] mem [0:369];
   logic [1:0] ph;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ph        <= 2'h0;
         rec_ready <= 1'b0;
      end else begin
         ph        <= ph + 2'h1;
         rec_ready <= !slow || (ph != 2'h0);
      end
   end

   // Bytes kept in arrival order, read back low byte first
   always_ff @(posedge pclk) begin
      if (clr) begin
         n        <= 0;
         last_at  <= -1;
         got_last <= 1'b0;
      end else if (rec_valid && rec_ready) begin
         if (n < 370) mem[n] <= rec_byte.data;
         n <= n + 1;
         if (rec_byte.last) begin
            last_at  <= n;
            got_last <= 1'b1;
         end
      end
   end
endmodule
`default_nettype wire

//--- tb/sra_status_record_assembler_tb_top.sv
// Purpose: Self-checking bench of the status record assembler
// Assumes: APB master tasks, sink model on the stream side
// Notes:   Expected record built from stimulus values only
`timescale 1ns/1ns
`default_nettype none
module sra_status_record_assembler_tb_top
   import sra_pkg::*;
;
   logic                pclk, presetn, psel, penable, pwrite, pready, pslverr, irq;
   logic                rec_valid, rec_ready, clr, slow, rerr;
   logic [11:0]         paddr;
   logic [31:0]         pwdata, prdata, rdat;
   logic [7:0]          thread_run;
   sra_plane_t          plane_s, plane_t;
   sra_axis_t [NAX-1:0] axis_in;
   sra_byte_t           rec_byte;
   logic [7:0]          exp_b [0:369];
   logic [8:0]          sels [4] = '{9'h014, 9'h100, 9'h080, 9'h101};
   int                  elen, error_cnt, total_checks;

   sra_status_record_assembler dut (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .irq(irq), .thread_run(thread_run),
      .plane_s(plane_s), .plane_t(plane_t), .axis_in(axis_in), .rec_valid(rec_valid),
      .rec_byte(rec_byte), .rec_ready(rec_ready));
   sra_rec_sink u_sink (.pclk(pclk), .presetn(presetn), .clr(clr), .slow(slow),
      .rec_valid(rec_valid), .rec_byte(rec_byte), .rec_ready(rec_ready), .n(),
      .last_at(), .got_last());

   always #10 pclk = ~pclk;

   // ------------------------------------------------------------
   // Stimulus values and expected record
   // ------------------------------------------------------------
   function automatic logic [31:0] fv(input int a, input int f);
      return (32'h01030507 * 32'(a + 1)) ^ (32'h9E3779B9 * 32'(f + 1));
   endfunction
   function automatic logic [31:0] tqi(input int a);
      logic [31:0] t [4] = '{32'h00012345, 32'hFFF00000, 32'h00001234, 32'hFFFF8000};
      return t[a % 4];
   endfunction
   function automatic logic [31:0] tqe(input int a);
      logic [31:0] t [4] = '{32'h00007FFF, 32'hFFFF8001, 32'h00001234, 32'hFFFF8001};
      return t[a % 4];
   endfunction
   function automatic logic [31:0] pw(input sra_plane_t q);
      return {16'h0, q.move, 9'h0, q.slewing, q.stopping, q.final_decel, 3'h0};
   endfunction
   task automatic put(input int o, input logic [31:0] v, input int nb);
      for (int k = 0; k < nb; k++) exp_b[o + k] = v[8*k +: 8];
   endtask
   task automatic mk(input logic [8:0] s);
      int         p;
      logic [5:0] w;
      p = 4;
      put(0, {16'h0, 1'b1, 4'h0, {3{s[8]}}, s[7:0]}, 2);
      if (s[8]) begin
         for (int k = 4; k < 82; k++) exp_b[k] = 8'h00;
         exp_b[51] = thread_run;
         put(64, pw(plane_s), 2);
         put(74, pw(plane_t), 2);
         p = 82;
      end
      for (int a = 0; a < NAX; a++) if (s[a]) begin
         w = 6'(fv(a, 1));
         put(p, fv(a, 0), 2);
         put(p + 2, {24'h0, w[5:4], 2'b00, w[3:0]}, 1);
         put(p + 3, fv(a, 2), 1);
         for (int f = 3; f < 7; f++) put(p + 4*f - 8, fv(a, f), 4);
         put(p + 20, fv(a, 7) << 6, 4);
         put(p + 24, tqe(a), 4);
         put(p + 28, fv(a, 8), 2);
         put(p + 30, fv(a, 9), 1);
         put(p + 31, 32'h0, 1);
         put(p + 32, fv(a, 10), 4);
         p = p + 36;
      end
      put(2, 32'(p), 2);
      elen = p;
   endtask

   // ------------------------------------------------------------
   // Bus and check tasks
   // ------------------------------------------------------------
   task automatic chk(input logic ok, input string m);
      total_checks++;
      if (ok !== 1'b1) begin
         error_cnt++;
         $display("BAD %0t %s", $time, m);
      end
   endtask
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      int k;
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      k = 0;
      do begin
         @(posedge pclk);
         k++;
      end while (pready !== 1'b1 && k < 50);
      chk(pready === 1'b1, "apb timeout");
      rdat = prdata;
      rerr = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask
   task automatic run(input logic [8:0] sw, input logic [8:0] s, input logic hit);
      int w;
      clr <= 1'b1;
      @(posedge pclk);
      clr <= 1'b0;
      mk(s);
      apb(1'b1, ADDR_SEL, {23'h0, sw});
      apb(1'b1, ADDR_CMD, 32'h1);
      if (hit) begin
         apb(1'b0, ADDR_STAT, 32'h0);
         chk(rdat[0] === 1'b1 && rdat[26:16] === 11'(elen), "busy flag");
         apb(1'b1, ADDR_CMD, 32'h1);
      end
      w = 0;
      while (u_sink.got_last !== 1'b1 && w < 3000) begin
         @(posedge pclk);
         w++;
      end
      chk(w < 3000, "record timeout");
      repeat (2) @(posedge pclk);
      chk(u_sink.n == elen, "byte count");
      chk(u_sink.last_at == elen - 1, "last flag");
      for (int k = 0; k < elen; k++) chk(u_sink.mem[k] === exp_b[k], "record byte");
   endtask
   task automatic end_of_test;
      $display("checks %0d errors %0d", total_checks, error_cnt);
      if (error_cnt == 0 && total_checks > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask

   initial begin
      repeat (20000) @(posedge pclk);
      error_cnt++;
      end_of_test;
   end

   // ------------------------------------------------------------
   // Main sequence
   // ------------------------------------------------------------
   initial begin
      pclk = 1'b0; presetn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
      paddr = 12'h000; pwdata = 32'h0; clr = 1'b1; slow = 1'b0;
      thread_run = 8'hA5; plane_s = 4'hB; plane_t = 4'h4;
      for (int a = 0; a < NAX; a++)
         axis_in[a] = {16'(fv(a, 0)), 6'(fv(a, 1)), 8'(fv(a, 2)), fv(a, 3), fv(a, 4),
            fv(a, 5), fv(a, 6), fv(a, 7), tqi(a), 16'(fv(a, 8)), 8'(fv(a, 9)), fv(a, 10)};
      repeat (6) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      apb(1'b0, ADDR_STAT, 32'h0);
      chk(rdat === 32'h0 && rerr === 1'b0, "stat after reset");
      apb(1'b0, 12'h014, 32'h0);
      chk(rerr === 1'b1 && rdat === 32'h0, "unmapped read");
      apb(1'b1, 12'h014, 32'hFFFFFFFF);
      chk(rerr === 1'b1, "unmapped write");
      slow <= 1'b1;
      run(9'h000, FULL_SEL, 1'b1);
      for (int a = 0; a < 4; a++) begin
         chk({u_sink.mem[82+36*a+23], u_sink.mem[82+36*a+22], u_sink.mem[82+36*a+21],
            u_sink.mem[82+36*a+20]} === fv(a, 7) << 6, "velocity scale");
         chk({u_sink.mem[82+36*a+27], u_sink.mem[82+36*a+26], u_sink.mem[82+36*a+25],
            u_sink.mem[82+36*a+24]} === tqe(a), "torque range");
      end
      apb(1'b0, ADDR_STAT, 32'h0);
      chk(rdat[26:16] === 11'h172 && rdat[0] === 1'b0, "stat length");
      apb(1'b0, ADDR_ISTAT, 32'h0);
      chk(rdat === 32'h3 && irq === 1'b0, "events masked");
      apb(1'b1, ADDR_IMASK, 32'h1);
      @(posedge pclk);
      chk(irq === 1'b1, "irq raised");
      apb(1'b1, ADDR_ISTAT, 32'h1);
      @(posedge pclk);
      chk(irq === 1'b0, "irq cleared");
      apb(1'b0, ADDR_ISTAT, 32'h0);
      chk(rdat === 32'h2, "busy event kept");
      apb(1'b1, ADDR_ISTAT, 32'h2);
      slow <= 1'b0;
      for (int i = 0; i < 4; i++) run(sels[i], sels[i], 1'b0);
      apb(1'b0, ADDR_SEL, 32'h0);
      chk(rdat === 32'h0000_0101 && rerr === 1'b0, "sel readback");
      end_of_test;
   end
endmodule
`default_nettype wire
